//--- design/i2cm_clkdiv.sv
// quarter-bit tick generator for the two-wire bus clock
module i2cm_clkdiv import i2cm_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic [1:0] bit_rate_select,
  input wire logic run,
  // tick out
  output logic tick
);
  typedef struct packed {
    logic [QDIV_W-1:0] cnt;
    logic tick;
  } i2cm_div_t;
  i2cm_div_t s_q, s_d;
  logic [QDIV_W-1:0] reload;

  always_comb begin
    reload = QDIV_W'((QUARTER_MIN << bit_rate_select) - 1);
    s_d = s_q;
    s_d.tick = 1'b0;
    // reload while stopped so the first phase of a frame is full length
    if (!run) begin
      s_d.cnt = reload;
    end else if (s_q.cnt == '0) begin
      s_d.cnt = reload;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

//--- design/i2cm_fifo.sv
// four-entry byte FIFO in flip-flops
module i2cm_fifo import i2cm_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flush,
  // filling side
  input wire logic push_valid,
  input wire logic [DATA_W-1:0] push_data,
  output logic push_ready,
  // draining side
  input wire logic pop_ready,
  output logic pop_valid,
  output logic [DATA_W-1:0] pop_data,
  output logic [CNT_W-1:0] fill
);
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][DATA_W-1:0] mem;
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic [CNT_W-1:0] cnt;
  } i2cm_fifo_t;
  i2cm_fifo_t s_q, s_d;
  logic do_push, do_pop;

  always_comb begin
    do_push = push_valid && push_ready;
    do_pop = pop_ready && pop_valid;
    s_d = s_q;
    if (do_push) begin
      s_d.mem[s_q.wp] = push_data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (do_pop) begin
      s_d.rp = s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + CNT_W'(do_push) - CNT_W'(do_pop);
    if (flush) begin
      s_d.wp = '0;
      s_d.rp = '0;
      s_d.cnt = '0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign push_ready = s_q.cnt != CNT_W'(FIFO_DEPTH);
  assign pop_valid = s_q.cnt != '0;
  assign pop_data = s_q.mem[s_q.rp];
  assign fill = s_q.cnt;
endmodule

//--- design/i2cm_top.sv
// two-wire bus master with byte registers and small FIFOs
module i2cm_top import i2cm_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pin ownership
  output logic pin_owner_select,
  // serial clock pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  // serial data pin
  input wire logic bus_data_pin_i,
  output logic bus_data_pin_o,
  output logic bus_data_pin_oe_n
);
  typedef struct packed {
    i2cm_state_t st;
    logic [1:0] ph;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic ack_smp;
    logic [5:0] rbytes;
    logic [7:0] bus_mode_config;
    logic [7:0] target_address;
    logic [7:0] cfg;
    logic pend;
    logic direction_bit;
    logic missing_ack_flag;
    logic receive_event_flag;
    logic transmit_event_flag;
    logic access_conflict_flag;
    logic tx_overfill_flag;
    logic [7:0] rdata;
    logic scl_low;
    logic sda_low;
  } i2cm_top_t;

  i2cm_top_t s_q, n;

  logic bus_enable_bit;
  logic [1:0] bit_rate_select;
  logic [4:0] receive_count_field;
  logic owned, busy, tick, stall, step, last;
  logic tx_push, tx_ready, tx_pop, tx_valid, tx_flush;
  logic rx_push, rx_ready, rx_pop, rx_valid;
  logic [7:0] tx_data, rx_data;
  logic [CNT_W-1:0] tx_fill, rx_fill, act_fill;
  logic [1:0] fifo_fill_level;
  logic [1:0] drv;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [1:0] fill_code(logic [CNT_W-1:0] cnt);
    if (cnt == '0) begin
      return LVL_EMPTY;
    end else if (cnt == CNT_W'(FIFO_DEPTH)) begin
      return LVL_FULL;
    end else begin
      return LVL_HALF;
    end
  endfunction

  // load a new transaction from the address register
  function automatic i2cm_top_t launch(i2cm_top_t x);
    x.st = ST_START;
    x.ph = PH_FIRST;
    x.pend = 1'b0;
    x.direction_bit = x.target_address[ADDR_DIR_BIT];
    x.sh = x.target_address;
    x.rbytes = '0;
    return x;
  endfunction

  // close a transaction: repeated start if a new address is waiting
  function automatic i2cm_top_t finish(i2cm_top_t x);
    if (x.pend) begin
      return launch(x);
    end
    x.st = ST_STOP;
    return x;
  endfunction

  // {scl_low, sda_low} for each state and phase
  function automatic logic [1:0] drive_of(i2cm_state_t st, logic [1:0] ph, logic bout,
                                          logic ack_low);
    logic edge_low;
    edge_low = (ph == PH_FIRST) || (ph == PH_LAST);
    unique case (st)
      ST_IDLE: return 2'b00;
      ST_START: return {edge_low, ph[1]};
      ST_STOP: return {ph == PH_FIRST, ph[1] == 1'b0};
      ST_ADDR, ST_WR_BIT: return {edge_low, ~bout};
      ST_ADDR_ACK, ST_WR_ACK, ST_RD_BIT: return {edge_low, 1'b0};
      ST_RD_ACK: return {edge_low, ack_low};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // FIFOs and bit clock

  i2cm_fifo u_tx_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(tx_flush),
    .push_valid(tx_push),
    .push_data(reg_wdata),
    .push_ready(tx_ready),
    .pop_ready(tx_pop),
    .pop_valid(tx_valid),
    .pop_data(tx_data),
    .fill(tx_fill)
  );

  i2cm_fifo u_rx_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(1'b0),
    .push_valid(rx_push),
    .push_data(s_q.sh),
    .push_ready(rx_ready),
    .pop_ready(rx_pop),
    .pop_valid(rx_valid),
    .pop_data(rx_data),
    .fill(rx_fill)
  );

  i2cm_clkdiv u_clkdiv (
    .clk(clk),
    .sys_rst(sys_rst),
    .bit_rate_select(bit_rate_select),
    .run(busy),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode

  assign bus_enable_bit = s_q.bus_mode_config[MODE_EN_BIT];
  assign bit_rate_select = s_q.bus_mode_config[MODE_RATE_LO +: 2];
  assign receive_count_field = s_q.bus_mode_config[MODE_RCT_LO +: 5];
  assign owned = s_q.cfg[CFG_OWNER_BIT] == OWNER_TWO_WIRE;
  assign busy = s_q.st != ST_IDLE;
  assign act_fill = s_q.direction_bit ? rx_fill : tx_fill;
  assign fifo_fill_level = fill_code(act_fill);
  // hold the clock low before the ack while the receive FIFO is full
  assign stall = (s_q.st == ST_RD_BIT) && (s_q.ph == PH_LAST) && (s_q.bitn == '0) && !rx_ready;
  assign step = tick && !stall;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = s_q;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    tx_flush = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    n.rdata = RDATA_RST;
    // registers are shared with the other peripheral at the same addresses
    if (reg_wr) begin
      case (reg_addr)
        OFS_MODE: n.bus_mode_config = reg_wdata;
        OFS_ADDR: begin
          n.target_address = reg_wdata;
          if (bus_enable_bit) begin
            n.pend = 1'b1;
          end
        end
        OFS_CFG: n.cfg = {7'h00, reg_wdata[CFG_OWNER_BIT]};
        OFS_STATUS: begin
          // only a 0 clears; a 1 leaves the flag alone
          n.missing_ack_flag = s_q.missing_ack_flag & reg_wdata[ST_NOACK];
          n.receive_event_flag = s_q.receive_event_flag & reg_wdata[ST_RXEV];
          n.transmit_event_flag = s_q.transmit_event_flag & reg_wdata[ST_TXEV];
          n.access_conflict_flag = s_q.access_conflict_flag & reg_wdata[ST_ACC];
          n.tx_overfill_flag = s_q.tx_overfill_flag & reg_wdata[ST_TXWR];
        end
        OFS_TX_BUF: begin
          if (!tx_ready) begin
            n.tx_overfill_flag = 1'b1;
          end else begin
            tx_push = 1'b1;
          end
          if (busy && s_q.direction_bit) begin
            n.access_conflict_flag = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_MODE: n.rdata = s_q.bus_mode_config;
        OFS_ADDR: n.rdata = s_q.target_address;
        OFS_CFG: n.rdata = s_q.cfg;
        OFS_STATUS: n.rdata = {busy, s_q.missing_ack_flag, s_q.receive_event_flag,
                               s_q.transmit_event_flag, fifo_fill_level,
                               s_q.access_conflict_flag, s_q.tx_overfill_flag};
        OFS_RX_BUF: begin
          n.rdata = rx_valid ? rx_data : RDATA_RST;
          rx_pop = 1'b1;
          if (busy && !s_q.direction_bit) begin
            n.access_conflict_flag = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // level events win over a clear in the same cycle
    if (rx_valid) begin
      n.receive_event_flag = 1'b1;
    end
    if (!tx_valid) begin
      n.transmit_event_flag = 1'b1;
    end
    // sequencer
    if (s_q.st == ST_IDLE) begin
      // wait for a free bus before the start condition
      if (s_q.pend && bus_enable_bit && owned && scl_i && bus_data_pin_i) begin
        n = launch(n);
      end
    end else if (step) begin
      n.ph = s_q.ph + 2'd1;
      if (s_q.ph == PH_SAMPLE) begin
        n.ack_smp = bus_data_pin_i;
        if (s_q.st == ST_RD_BIT) begin
          n.sh = {s_q.sh[6:0], bus_data_pin_i};
        end
      end
      if (s_q.ph == PH_LAST) begin
        unique case (s_q.st)
          ST_START: begin
            n.st = ST_ADDR;
            n.bitn = BIT_MSB;
          end
          ST_ADDR, ST_WR_BIT: begin
            n.sh = {s_q.sh[6:0], 1'b0};
            if (s_q.bitn == '0) begin
              n.st = (s_q.st == ST_ADDR) ? ST_ADDR_ACK : ST_WR_ACK;
            end else begin
              n.bitn = s_q.bitn - 3'd1;
            end
          end
          ST_ADDR_ACK, ST_WR_ACK: begin
            if (s_q.ack_smp) begin
              n.missing_ack_flag = 1'b1;
              n.st = ST_STOP;
              tx_flush = !s_q.direction_bit;
            end else if (s_q.st == ST_ADDR_ACK && s_q.direction_bit) begin
              n.st = ST_RD_BIT;
              n.bitn = BIT_MSB;
            end else if (tx_valid) begin
              tx_pop = 1'b1;
              n.sh = tx_data;
              n.st = ST_WR_BIT;
              n.bitn = BIT_MSB;
            end else begin
              n = finish(n);
            end
          end
          ST_RD_BIT: begin
            if (s_q.bitn == '0) begin
              rx_push = 1'b1;
              n.rbytes = s_q.rbytes + 6'd1;
              n.st = ST_RD_ACK;
            end else begin
              n.bitn = s_q.bitn - 3'd1;
            end
          end
          ST_RD_ACK: begin
            if (s_q.rbytes == {1'b0, receive_count_field} + 6'd1) begin
              n = finish(n);
            end else begin
              n.st = ST_RD_BIT;
              n.bitn = BIT_MSB;
            end
          end
          ST_STOP: n.st = ST_IDLE;
        endcase
      end
    end
    last = n.rbytes == {1'b0, n.bus_mode_config[MODE_RCT_LO +: 5]} + 6'd1;
    drv = drive_of(n.st, n.ph, n.sh[7], !last);
    n.scl_low = drv[1];
    n.sda_low = drv[0];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{st: ST_IDLE, bus_mode_config: MODE_RST, target_address: ADDR_RST,
               cfg: CFG_RST, rdata: RDATA_RST, default: '0};
    end else begin
      s_q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs: pins only ever pulled low, never driven high

  assign reg_rdata = s_q.rdata;
  assign pin_owner_select = s_q.cfg[CFG_OWNER_BIT];
  assign scl_o = 1'b0;
  assign bus_data_pin_o = 1'b0;
  assign scl_oe_n = !(owned && s_q.scl_low);
  assign bus_data_pin_oe_n = !(owned && s_q.sda_low);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_start_on_addr: assert property (
    (reg_wr && reg_addr == OFS_ADDR && bus_enable_bit && !busy && owned && scl_i
     && bus_data_pin_i && !$past(reg_wr)) ##1 (owned && scl_i && bus_data_pin_i)
    |=> s_q.st == ST_START)
    else $error("address write with enable did not start a transaction");

  a_no_start_off: assert property (
    (reg_wr && reg_addr == OFS_ADDR && !bus_enable_bit && !busy && !s_q.pend)
    |=> ##1 !busy)
    else $error("transaction started while disabled");

  a_noack_stops: assert property (
    $rose(s_q.missing_ack_flag) && busy |-> s_q.st == ST_STOP)
    else $error("missing acknowledge did not halt the transfer");

  a_err_flush: assert property (
    $rose(s_q.missing_ack_flag) && busy && !s_q.direction_bit |-> tx_fill == '0)
    else $error("transmit FIFO not flushed after write error");

  a_overfill_set: assert property (
    reg_wr && reg_addr == OFS_TX_BUF && tx_fill == CNT_W'(FIFO_DEPTH)
    |=> s_q.tx_overfill_flag && tx_fill == CNT_W'(FIFO_DEPTH))
    else $error("overfill flag not set on write to full FIFO");

  a_one_keeps: assert property (
    reg_wr && reg_addr == OFS_STATUS && reg_wdata[ST_NOACK] && s_q.missing_ack_flag
    |=> s_q.missing_ack_flag)
    else $error("writing 1 cleared a status flag");

  a_rx_event: assert property (
    rx_fill != '0 |=> s_q.receive_event_flag)
    else $error("receive flag low with data in FIFO");

  a_tx_event: assert property (
    tx_fill == '0 |=> s_q.transmit_event_flag)
    else $error("transmit flag low with empty FIFO");

  a_level_full: assert property (
    reg_rd && reg_addr == OFS_STATUS && act_fill == CNT_W'(FIFO_DEPTH)
    |=> reg_rdata[ST_LVL_LO +: 2] == LVL_FULL)
    else $error("full FIFO not reported as full");

  a_owner_release: assert property (
    !owned |-> scl_oe_n && bus_data_pin_oe_n)
    else $error("pins pulled while owned by the other peripheral");

  a_last_nack: assert property (
    s_q.st == ST_RD_ACK && s_q.rbytes == {1'b0, receive_count_field} + 6'd1
    |-> !s_q.sda_low)
    else $error("last read byte was acknowledged");

  a_idle_release: assert property (
    !busy |-> !s_q.scl_low && !s_q.sda_low)
    else $error("bus lines pulled while idle");

  c_read_done: cover property (s_q.st == ST_RD_ACK ##1 n.st == ST_STOP);
  c_write_done: cover property (s_q.st == ST_WR_ACK && n.st == ST_STOP && !s_q.ack_smp);
  c_restart: cover property (s_q.st != ST_IDLE && s_q.st != ST_STOP && n.st == ST_START);
  c_noack: cover property ($rose(s_q.missing_ack_flag));
endmodule

//--- inc/i2cm_pkg.sv
// constants, types and behaviour summary of the two-wire bus master
// Function
// - the block is only a bus master and makes the serial clock itself
// - one configuration bit hands the shared pins to this block or the other peripheral
// - both bus lines are open-drain, wired-AND; there is no arbitration, only a free-bus check before the start
// - start only on an idle bus, send address and direction, stop at the end
// - rate field divides core clock by 16, 32, 64 or 128
// - with the enable bit set, any target address write starts a transaction
// - address bits 7..1 are the target, bit 0 high reads, low writes
// - a read ends after receive count plus one bytes, or on an error
// - busy flag reads 1 while the bus is in use; transmit FIFO drains then
// - missing acknowledge sets a flag and halts; cleared by writing 0
// - receive flag set while receive FIFO holds a byte; cleared by writing 0
// - transmit flag set while transmit FIFO is empty; cleared by writing 0
// - fill level of the active FIFO: 00 empty, 10 half, 11 full
// - access conflict flag set on simultaneous write and read; cleared by writing 0
// - overfill flag set on transmit write into a full FIFO; cleared by writing 0
// - mode, address and status share addresses with the other peripheral; buffers are common
// - four-byte receive FIFO and separate four-byte transmit FIFO
// - during a read, acknowledge each byte and no-acknowledge the last
// - address rewritten mid-transaction gives a repeated start instead of a stop
// - a write stops when no byte is ready; an error in a write flushes the transmit FIFO
package i2cm_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned PTR_W = 2;
  localparam int unsigned CNT_W = 3;
  localparam int unsigned QDIV_W = 5;
  // register map
  localparam logic [7:0] OFS_TX_BUF = 8'h9a;
  localparam logic [7:0] OFS_RX_BUF = 8'h9b;
  localparam logic [7:0] OFS_MODE = 8'he8;
  localparam logic [7:0] OFS_ADDR = 8'he9;
  localparam logic [7:0] OFS_STATUS = 8'hea;
  localparam logic [7:0] OFS_CFG = 8'haf;
  // values after reset
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  // field positions
  localparam int unsigned MODE_EN_BIT = 7;
  localparam int unsigned MODE_RATE_LO = 5;
  localparam int unsigned MODE_RCT_LO = 0;
  localparam int unsigned ADDR_DIR_BIT = 0;
  localparam int unsigned ST_BUSY = 7;
  localparam int unsigned ST_NOACK = 6;
  localparam int unsigned ST_RXEV = 5;
  localparam int unsigned ST_TXEV = 4;
  localparam int unsigned ST_LVL_LO = 2;
  localparam int unsigned ST_ACC = 1;
  localparam int unsigned ST_TXWR = 0;
  localparam int unsigned CFG_OWNER_BIT = 0;
  localparam logic OWNER_TWO_WIRE = 1'b1;
  // fill level codes
  localparam logic [1:0] LVL_EMPTY = 2'b00;
  localparam logic [1:0] LVL_HALF = 2'b10;
  localparam logic [1:0] LVL_FULL = 2'b11;
  // bit timing: four phases per bit, smallest divider 16
  localparam int unsigned BIT_DIV_MIN = 16;
  localparam int unsigned PHASES_PER_BIT = 4;
  localparam int unsigned QUARTER_MIN = BIT_DIV_MIN / PHASES_PER_BIT;
  localparam logic [1:0] PH_FIRST = 2'd0;
  localparam logic [1:0] PH_SAMPLE = 2'd2;
  localparam logic [1:0] PH_LAST = 2'd3;
  localparam logic [2:0] BIT_MSB = 3'd7;
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_ADDR, ST_ADDR_ACK, ST_WR_BIT, ST_WR_ACK,
    ST_RD_BIT, ST_RD_ACK, ST_STOP
  } i2cm_state_t;
endpackage

//--- test/i2cm_slave_model.sv
// behavioural two-wire target device facing the bus master
module i2cm_slave_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  // clock
  input wire logic clk,
  // bus lines as seen on the wire
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe_n
);
  logic [7:0] rd_q[$];
  logic [7:0] got[$];
  int n_sent = 0;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic [7:0] sh;
  logic [7:0] tx;
  logic [7:0] tx_n;
  logic go;
  int cnt = 0;
  int mode = 0;
  initial sda_oe_n = 1'b1;
  ////////////////////////////////////////////////////////////////////////////////
  // edges seen a cycle late; data only moves while the clock line is low
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) begin
      cnt <= 0;
      mode <= 1;
      sda_oe_n <= 1'b1;
    end else if (scl && scl_q && !sda_q && sda) begin
      mode <= 0;
      sda_oe_n <= 1'b1;
    end else if (mode != 0 && scl && !scl_q) begin
      if (cnt < 8) sh <= {sh[6:0], sda};
      if (cnt == 8 && mode == 3) go <= !sda;
      cnt <= cnt + 1;
    end else if (mode != 0 && !scl && scl_q) begin
      if (cnt == 8) begin
        if (mode == 1 && sh[7:1] == DEV_ADDR) begin
          sda_oe_n <= 1'b0;
          mode <= sh[0] ? 3 : 2;
          go <= 1'b1;
        end else if (mode == 1) begin
          mode <= 0;
        end else if (mode == 2) begin
          got.push_back(sh);
          sda_oe_n <= 1'b0;
        end else begin
          sda_oe_n <= 1'b1;
        end
      end else if (cnt == 9) begin
        cnt <= 0;
        if (mode == 3 && go) begin
          tx_n = (rd_q.size() > 0) ? rd_q.pop_front() : 8'hff;
          tx <= tx_n;
          n_sent <= n_sent + 1;
          sda_oe_n <= tx_n[7];
        end else begin
          sda_oe_n <= 1'b1;
          if (mode == 3) mode <= 0;
        end
      end else if (mode == 3 && cnt > 0 && cnt < 8) begin
        sda_oe_n <= tx[7 - cnt];
      end
    end
  end
endmodule

//--- test/i2cm_top_tb.sv
// self-checking bench for the two-wire bus master
module i2cm_top_tb import i2cm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV = 7'h2a;
  // registers that read 0 after reset, plus one unmapped address
  localparam logic [7:0] RST_ADDRS [5] = '{OFS_MODE, OFS_ADDR, OFS_RX_BUF, OFS_CFG, 8'h10};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic pin_owner_select;
  logic scl_oe_n;
  logic bus_data_pin_oe_n;
  logic slv_oe_n;
  wire scl_w = scl_oe_n;
  // pull-up: the line is low only while some party pulls it
  wire sda_w = bus_data_pin_oe_n & slv_oe_n;
  int n_mismatch = 0;
  int num_checks = 0;
  int seed = 32'heee6;
  int cyc = 0;
  int last_rise = 0;
  int per = 0;
  logic [7:0] rv;
  logic [7:0] s;
  logic [7:0] exp_q[$];
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge scl_w) begin
    per = cyc - last_rise;
    last_rise = cyc;
  end
  ////////////////////////////////////////////////////////////////////////////////
  i2cm_top i2cm_top_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_owner_select(pin_owner_select), .scl_i(scl_w), .scl_o(), .scl_oe_n(scl_oe_n),
    .bus_data_pin_i(sda_w), .bus_data_pin_o(), .bus_data_pin_oe_n(bus_data_pin_oe_n));
  i2cm_slave_model #(.DEV_ADDR(DEV)) i2cm_slave_model_inst (.clk(clk), .scl(scl_w),
    .sda(sda_w), .sda_oe_n(slv_oe_n));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // start a transfer, look at busy, then poll it down under a bound
  task automatic xfer(input logic [7:0] m, input logic [7:0] a, input logic b, input logic cf);
    int i;
    wr(OFS_MODE, m);
    wr(OFS_ADDR, a);
    repeat (2) @(posedge clk);
    rd(OFS_STATUS, s);
    chk("busy", {7'h00, s[ST_BUSY]}, {7'h00, b});
    if (cf) wr(OFS_TX_BUF, 8'h5a);
    for (i = 0; i < 5000; i++) begin
      rd(OFS_STATUS, s);
      if (s[ST_BUSY] === 1'b0) break;
    end
    if (i == 5000) begin
      n_mismatch++;
      $display("[FAIL] busy wait expected 00 seen 80");
      stop_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (RST_ADDRS[i]) begin
      rd(RST_ADDRS[i], s);
      chk("reset value", s, 8'h00);
    end
    rd(OFS_STATUS, s);
    chk("status reset", s, 8'h10);
    wr(OFS_CFG, 8'h01);
    // the owner flop updates on the edge that ends the write: look once it has settled
    @(negedge clk);
    chk("pin owner", {7'h00, pin_owner_select}, 8'h01);
    $display("test reset done");
    for (int r = 0; r < 4; r++) begin
      exp_q.delete();
      i2cm_slave_model_inst.got.delete();
      for (int k = 0; k <= r + (r == 3); k++) begin
        rv = 8'($random(seed));
        wr(OFS_TX_BUF, rv);
        if (k < 4) exp_q.push_back(rv);
      end
      if (r == 3) begin
        rd(OFS_STATUS, s);
        chk("full level", s & 8'h0d, 8'h0d);
        wr(OFS_STATUS, 8'hff);
        rd(OFS_STATUS, s);
        chk("overfill kept", s & 8'h01, 8'h01);
        wr(OFS_STATUS, 8'hfe);
        rd(OFS_STATUS, s);
        chk("overfill clear", s & 8'h01, 8'h00);
      end
      xfer({1'b1, 2'(r), 5'h00}, {DEV, 1'b0}, 1'b1, 1'b0);
      chk("bit period", 8'(per), 8'(16 << r));
      chk("idle status", s & 8'h9c, 8'h10);
      chk("sent count", 8'(i2cm_slave_model_inst.got.size()), 8'(exp_q.size()));
      foreach (exp_q[i]) chk("sent byte", i2cm_slave_model_inst.got[i], exp_q[i]);
    end
    $display("test write done");
    xfer(8'h00, {DEV, 1'b0}, 1'b0, 1'b0);
    wr(OFS_TX_BUF, 8'h11);
    wr(OFS_TX_BUF, 8'h22);
    xfer(8'h80, {DEV ^ 7'h01, 1'b0}, 1'b1, 1'b0);
    chk("no ack", s & 8'h4c, 8'h40);
    wr(OFS_STATUS, 8'hff);
    rd(OFS_STATUS, s);
    chk("no ack kept", s & 8'h40, 8'h40);
    wr(OFS_STATUS, 8'hbf);
    rd(OFS_STATUS, s);
    chk("no ack clear", s & 8'h40, 8'h00);
    $display("test no ack done");
    exp_q.delete();
    i2cm_slave_model_inst.n_sent = 0;
    for (int k = 0; k < 3; k++) begin
      rv = 8'($random(seed));
      i2cm_slave_model_inst.rd_q.push_back(rv);
      exp_q.push_back(rv);
    end
    xfer({3'b100, 5'd2}, {DEV, 1'b1}, 1'b1, 1'b1);
    chk("read status", s & 8'h2e, 8'h2a);
    chk("read length", 8'(i2cm_slave_model_inst.n_sent), 8'h03);
    foreach (exp_q[i]) begin
      rd(OFS_RX_BUF, s);
      chk("read byte", s, exp_q[i]);
    end
    rd(OFS_RX_BUF, s);
    chk("empty read", s, 8'h00);
    wr(OFS_STATUS, 8'hdf);
    rd(OFS_STATUS, s);
    chk("rx flag clear", s & 8'h20, 8'h00);
    $display("test read done");
    stop_test();
  end
endmodule
